// *** src/tmr8_core.sv ***
// tmr8_core: 8-bit timer/counter with two compare channels and pin override
// assumes all inputs synchronous to clk; the oscillator clock is pre-synced
//
// Behaviour
// - tick from io clock or oscillator
// - clock select zero stops the counter
// - counter readable and writable at any time
// - cpu write beats clear and count
// - bottom, max and top signalled
// - three-bit waveform mode selects the sequence
// - match sets compare flag next tick
// - flag cleared by service or one-write
// - requests visible in flags, individually masked
// - compare buffered in pwm modes only
// - cpu writes reach buffer or active
// - force strobe changes output, not flag, in non-pwm modes
// - counter write blocks next-tick matches
// - output state kept across mode change
// - output mode bits act immediately
// - nonzero output mode overrides port value
// - overflow flag set per waveform mode
// - power-off bit stops the counter tick
// - mode zero wraps, overflow at zero
// - mode two clears on compare a
// - output mode zero changes nothing
`timescale 1ns/1ps
module tmr8_core
(
	input  wire logic                  clk,              // io clock, 50 MHz
	input  wire logic                  rst_b,            // async reset, active low
	input  wire logic                  timer_power_off_bit, // counter tick stopped
	input  wire logic                  async_clock_select, // use oscillator tick
	input  wire logic                  osc_tick,         // synced oscillator tick pulse
	input  wire logic [2:0]            clock_select_field, // source / prescale
	input  wire logic [2:0]            waveform_mode_field, // counting sequence
	input  wire tmr8_pkg::tmr8_com_t   compare_output_mode, // per-channel output mode
	input  wire tmr8_pkg::tmr8_cnt_wr_t cnt_wr,          // counter_value write
	input  wire logic                  cmp_a_wr,         // compare_a_value write
	input  wire logic                  cmp_b_wr,         // compare_b_value write
	input  wire logic [7:0]            cmp_wdata,        // compare write data
	input  wire logic [1:0]            force_compare_strobe, // b,a force pulses
	input  wire logic [2:0]            flag_clr,         // write-one-to-clear flags
	input  wire logic [2:0]            flag_ack,         // interrupt serviced pulses
	input  wire logic [2:0]            interrupt_mask_reg, // mask bits
	input  wire logic [1:0]            port_value,       // b,a general port values
	output logic [7:0]                 counter_value,    // counter readback
	output logic [7:0]                 compare_a_value,  // cpu view of compare a
	output logic [7:0]                 compare_b_value,  // cpu view of compare b
	output logic [2:0]                 interrupt_flag_reg, // flag readback
	output logic [2:0]                 irq,              // flag and mask requests
	output logic                       compare_a_output, // pin value channel a
	output logic                       compare_b_output  // pin value channel b
);
	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic is_pwm(input logic [2:0] wm);
		is_pwm = (wm != tmr8_pkg::WM_NORMAL) && (wm != tmr8_pkg::WM_CTC);
	endfunction : is_pwm

	function automatic logic apply_com(input logic [1:0] m, input logic cur);
		unique case (m)
			tmr8_pkg::COM_NONE:   apply_com = cur;
			tmr8_pkg::COM_TOGGLE: apply_com = ~cur;
			tmr8_pkg::COM_CLEAR:  apply_com = 1'b0;
			tmr8_pkg::COM_SET:    apply_com = 1'b1;
		endcase
	endfunction : apply_com

	////////////////////////////////////////////////////////////////////////
	// prescaler and tick
	logic [tmr8_pkg::PRESCALE_W-1:0] pre_reg, pre_next;
	logic                             tick;
	logic                             sel_tick;

	// prescale tap select
	always_comb
	begin
		pre_next = pre_reg + 1'b1;
		unique case (clock_select_field)
			tmr8_pkg::CLK_DIV1:    sel_tick = 1'b1;
			tmr8_pkg::CLK_DIV8:    sel_tick = (pre_reg[2:0] == 3'h7);
			tmr8_pkg::CLK_DIV32:   sel_tick = (pre_reg[4:0] == 5'h1F);
			tmr8_pkg::CLK_DIV64:   sel_tick = (pre_reg[5:0] == 6'h3F);
			tmr8_pkg::CLK_DIV128:  sel_tick = (pre_reg[6:0] == 7'h7F);
			tmr8_pkg::CLK_DIV256:  sel_tick = (pre_reg[7:0] == 8'hFF);
			tmr8_pkg::CLK_DIV1024: sel_tick = (pre_reg == 10'h3FF);
			default:               sel_tick = 1'b0;
		endcase
		if (async_clock_select)
			sel_tick = sel_tick & osc_tick;
		if ((clock_select_field == tmr8_pkg::CLK_STOP) || timer_power_off_bit)
			sel_tick = 1'b0;
		tick = sel_tick;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pre_reg <= '0;
		else
			pre_reg <= pre_next;
	end

	////////////////////////////////////////////////////////////////////////
	// counter unit
	logic [7:0] cnt_reg, cnt_next;
	logic       dir_down_reg, dir_down_next;
	logic [7:0] ocr_a_reg, ocr_a_next, ocr_b_reg, ocr_b_next;
	logic [7:0] buf_a_reg, buf_a_next, buf_b_reg, buf_b_next;
	logic [7:0] view_a_reg, view_a_next, view_b_reg, view_b_next;
	logic       block_reg, block_next;
	logic [2:0] flg_reg, flg_next;
	logic [1:0] oc_reg, oc_next;
	logic [1:0] pin_reg, pin_next;
	logic [2:0] irq_reg, irq_next;
	logic [7:0] top_val;
	logic       at_top, at_bottom, at_max, pc_mode, ovf_set;
	logic       match_a, match_b;
	logic       sbot, stop_evt;

	always_comb
	begin
		pc_mode   = (waveform_mode_field[1:0] == 2'h1);
		top_val   = (waveform_mode_field[2] || waveform_mode_field == tmr8_pkg::WM_CTC)
			? ocr_a_reg : tmr8_pkg::MAX_VAL;
		at_top    = (cnt_reg == top_val);
		at_bottom = (cnt_reg == tmr8_pkg::BOTTOM_VAL);
		at_max    = (cnt_reg == tmr8_pkg::MAX_VAL);
		match_a   = tick && !block_reg && (cnt_reg == ocr_a_reg);
		match_b   = tick && !block_reg && (cnt_reg == ocr_b_reg);
	end

	always_comb
	begin
		cnt_next      = cnt_reg;
		dir_down_next = dir_down_reg;
		ovf_set       = 1'b0;
		sbot          = 1'b0;
		stop_evt      = 1'b0;
		if (tick)
		begin
			if (pc_mode)
			begin
				if (!dir_down_reg && at_top)
				begin
					dir_down_next = 1'b1;
					cnt_next      = cnt_reg - 1'b1;
					stop_evt      = 1'b1;
				end
				else if (dir_down_reg && at_bottom)
				begin
					dir_down_next = 1'b0;
					cnt_next      = cnt_reg + 1'b1;
					ovf_set       = 1'b1;
					sbot          = 1'b1;
				end
				else
					cnt_next = dir_down_reg ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
			end
			else if (at_top && waveform_mode_field != tmr8_pkg::WM_NORMAL)
			begin
				cnt_next = tmr8_pkg::BOTTOM_VAL;
				sbot     = 1'b1;
				ovf_set  = is_pwm(waveform_mode_field) || at_max;
				stop_evt = 1'b1;
			end
			else
			begin
				cnt_next      = cnt_reg + 1'b1;
				dir_down_next = 1'b0;
				ovf_set       = at_max;
				sbot          = at_max;
			end
		end
		if (cnt_wr.wr)
			cnt_next = cnt_wr.data;
		block_next = cnt_wr.wr ? 1'b1 : (tick ? 1'b0 : block_reg);
	end

	always_comb
	begin
		buf_a_next = cmp_a_wr ? cmp_wdata : buf_a_reg;
		buf_b_next = cmp_b_wr ? cmp_wdata : buf_b_reg;
		ocr_a_next = ocr_a_reg;
		ocr_b_next = ocr_b_reg;
		if (!is_pwm(waveform_mode_field))
		begin
			if (cmp_a_wr)
				ocr_a_next = cmp_wdata;
			if (cmp_b_wr)
				ocr_b_next = cmp_wdata;
		end
		else if ((pc_mode && stop_evt) || (!pc_mode && sbot))
		begin
			ocr_a_next = buf_a_reg;
			ocr_b_next = buf_b_reg;
		end
		// cpu view follows the access target, registered for the compare value readback
		view_a_next = is_pwm(waveform_mode_field) ? buf_a_next : ocr_a_next;
		view_b_next = is_pwm(waveform_mode_field) ? buf_b_next : ocr_b_next;
	end

	// compare output state and flags
	always_comb
	begin
		logic [1:0] m;
		logic [1:0] mm;
		logic [1:0] frc;
		m   = tmr8_pkg::COM_NONE;
		mm  = {match_b, match_a};
		frc = is_pwm(waveform_mode_field) ? 2'h0 : force_compare_strobe;
		oc_next = oc_reg;
		for (int i = 0; i < 2; i++)
		begin
			m = (i == 0) ? compare_output_mode.mode_a : compare_output_mode.mode_b;
			if (!is_pwm(waveform_mode_field))
			begin
				if (mm[i] || frc[i])
					oc_next[i] = apply_com(m, oc_reg[i]);
			end
			else if (m[1])
			begin
				if (mm[i])
					oc_next[i] = m[0] ^ (pc_mode & dir_down_reg) ? 1'b1 : 1'b0;
				else if (!pc_mode && sbot)
					oc_next[i] = ~m[0];
			end
		end
		pin_next[0] = (compare_output_mode.mode_a != tmr8_pkg::COM_NONE)
			? oc_next[0] : port_value[0];
		pin_next[1] = (compare_output_mode.mode_b != tmr8_pkg::COM_NONE)
			? oc_next[1] : port_value[1];
		flg_next = flg_reg & ~(flag_clr | flag_ack);
		flg_next[tmr8_pkg::FLG_OVF]  = flg_next[tmr8_pkg::FLG_OVF] | ovf_set;
		flg_next[tmr8_pkg::FLG_CMPA] = flg_next[tmr8_pkg::FLG_CMPA] | match_a;
		flg_next[tmr8_pkg::FLG_CMPB] = flg_next[tmr8_pkg::FLG_CMPB] | match_b;
		irq_next = flg_next & interrupt_mask_reg;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_reg      <= tmr8_pkg::CNT_RST;
			dir_down_reg <= 1'b0;
			ocr_a_reg    <= tmr8_pkg::CMP_RST;
			ocr_b_reg    <= tmr8_pkg::CMP_RST;
			buf_a_reg    <= tmr8_pkg::CMP_RST;
			buf_b_reg    <= tmr8_pkg::CMP_RST;
			view_a_reg   <= tmr8_pkg::CMP_RST;
			view_b_reg   <= tmr8_pkg::CMP_RST;
			block_reg    <= 1'b0;
			flg_reg      <= tmr8_pkg::FLAGS_RST;
			oc_reg       <= 2'h0;
			pin_reg      <= 2'h0;
			irq_reg      <= 3'h0;
		end
		else
		begin
			cnt_reg      <= cnt_next;
			dir_down_reg <= dir_down_next;
			ocr_a_reg    <= ocr_a_next;
			ocr_b_reg    <= ocr_b_next;
			buf_a_reg    <= buf_a_next;
			buf_b_reg    <= buf_b_next;
			view_a_reg   <= view_a_next;
			view_b_reg   <= view_b_next;
			block_reg    <= block_next;
			flg_reg      <= flg_next;
			oc_reg       <= oc_next;
			pin_reg      <= pin_next;
			irq_reg      <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops
	assign counter_value      = cnt_reg;
	assign compare_a_value    = view_a_reg;
	assign compare_b_value    = view_b_reg;
	assign interrupt_flag_reg = flg_reg;
	assign irq                = irq_reg;
	assign compare_a_output   = pin_reg[0];
	assign compare_b_output   = pin_reg[1];
endmodule : tmr8_core

// *** src/tmr8_pkg.sv ***
// tmr8_pkg: constants and carrier types for the 8-bit compare timer core
// assumes one synchronous clock domain; control bits arrive as plain ports
package tmr8_pkg;
	localparam logic [7:0] BOTTOM_VAL  = 8'h00;
	localparam logic [7:0] MAX_VAL     = 8'hFF;
	localparam logic [7:0] CNT_RST     = 8'h00;
	localparam logic [7:0] CMP_RST     = 8'h00;
	localparam logic [2:0] CLK_STOP    = 3'h0;
	localparam logic [2:0] CLK_DIV1    = 3'h1;
	localparam logic [2:0] CLK_DIV8    = 3'h2;
	localparam logic [2:0] CLK_DIV32   = 3'h3;
	localparam logic [2:0] CLK_DIV64   = 3'h4;
	localparam logic [2:0] CLK_DIV128  = 3'h5;
	localparam logic [2:0] CLK_DIV256  = 3'h6;
	localparam logic [2:0] CLK_DIV1024 = 3'h7;
	localparam int         PRESCALE_W  = 10;
	// waveform mode codes
	localparam logic [2:0] WM_NORMAL   = 3'h0;
	localparam logic [2:0] WM_PC_MAX   = 3'h1;
	localparam logic [2:0] WM_CTC      = 3'h2;
	localparam logic [2:0] WM_FAST_MAX = 3'h3;
	localparam logic [2:0] WM_PC_CMPA  = 3'h5;
	localparam logic [2:0] WM_FAST_CMPA = 3'h7;
	// compare output mode codes
	localparam logic [1:0] COM_NONE    = 2'h0;
	localparam logic [1:0] COM_TOGGLE  = 2'h1;
	localparam logic [1:0] COM_CLEAR   = 2'h2;
	localparam logic [1:0] COM_SET     = 2'h3;
	// flag bit positions in interrupt_flag_reg / interrupt_mask_reg
	localparam int         FLG_OVF     = 0;
	localparam int         FLG_CMPA    = 1;
	localparam int         FLG_CMPB    = 2;
	localparam logic [2:0] FLAGS_RST   = 3'h0;

	typedef struct packed {
		logic       wr;   // counter_value write strobe
		logic [7:0] data; // value written
	} tmr8_cnt_wr_t;

	typedef struct packed {
		logic [1:0] mode_b; // compare_output_mode channel B
		logic [1:0] mode_a; // compare_output_mode channel A
	} tmr8_com_t;
endpackage : tmr8_pkg

// *** test/tb_top.sv ***
// tb_top: directed bench for the 8-bit compare timer core
// assumes the core samples every input on the rising edge of clk
`timescale 1ns/1ps
module tb_top;
	logic			clk = 1'b0;
	logic			rst_b = 1'b0;
	logic			pwr = 1'b0;
	logic			asel = 1'b0;
	logic			osc = 1'b0;
	logic [2:0]		cs = 3'h0;
	logic [2:0]		wm = 3'h0;
	tmr8_pkg::tmr8_com_t	com = '0;
	tmr8_pkg::tmr8_cnt_wr_t	cw = '0;
	logic			cwa = 1'b0;
	logic			cwb = 1'b0;
	logic [7:0]		cwd = 8'h00;
	logic [1:0]		frc = 2'h0;
	logic [2:0]		fclr = 3'h0;
	logic [2:0]		fack = 3'h0;
	logic [2:0]		msk = 3'h0;
	logic [1:0]		pv = 2'h0;
	logic [7:0]		cnt;
	logic [7:0]		cva;
	logic [7:0]		cvb;
	logic [2:0]		flg;
	logic [2:0]		irq;
	logic			oa;
	logic			ob;
	int			n_errors = 0;
	int			cmp_count = 0;
	logic [1:0]		fm [3] = '{tmr8_pkg::COM_SET, tmr8_pkg::COM_CLEAR, tmr8_pkg::COM_TOGGLE};
	always #10 clk = ~clk;
	tmr8_core uut (.clk(clk), .rst_b(rst_b), .timer_power_off_bit(pwr),
		.async_clock_select(asel), .osc_tick(osc), .clock_select_field(cs),
		.waveform_mode_field(wm), .compare_output_mode(com), .cnt_wr(cw), .cmp_a_wr(cwa),
		.cmp_b_wr(cwb), .cmp_wdata(cwd), .force_compare_strobe(frc), .flag_clr(fclr),
		.flag_ack(fack), .interrupt_mask_reg(msk), .port_value(pv), .counter_value(cnt),
		.compare_a_value(cva), .compare_b_value(cvb), .interrupt_flag_reg(flg), .irq(irq),
		.compare_a_output(oa), .compare_b_output(ob));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
		end
	endtask : cyc
	task automatic final_report;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one-cycle cpu writes of counter, compare a and compare b
	task automatic wr_cnt(input logic [7:0] d);
		cw = '{wr: 1'b1, data: d};
		cyc(1);
		cw.wr = 1'b0;
	endtask : wr_cnt
	task automatic wr_cmp(input logic [7:0] d);
		cwa = 1'b1;
		cwd = d;
		cyc(1);
		cwa = 1'b0;
	endtask : wr_cmp
	task automatic wr_cmpb(input logic [7:0] d);
		cwb = 1'b1;
		cwd = d;
		cyc(1);
		cwb = 1'b0;
	endtask : wr_cmpb
	task automatic wait_flag(input int b);
		for (int i = 0; i < 400 && flg[b] !== 1'b1; i++)
			cyc(1);
		chk({7'h00, flg[b]}, 8'h01);
		if (flg[b] !== 1'b1)
			final_report();
	endtask : wait_flag
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(16);
		rst_b = 1'b1;
		cyc(1);
		wr_cnt(8'h5A);
		cyc(4);
		chk(cnt, 8'h5A);
		wr_cnt(8'h10);
		wr_cmp(8'h10);
		fclr = 3'h7;
		msk = 3'h3;
		cyc(1);
		fclr = 3'h0;
		cs = tmr8_pkg::CLK_DIV1;
		cyc(3);
		chk({5'h00, flg}, 8'h00);
		wait_flag(tmr8_pkg::FLG_CMPA);
		chk(cnt, 8'h11);
		chk({5'h00, flg}, 8'h07);
		chk({5'h00, irq}, 8'h03);
		fclr = 3'h2;
		fack = 3'h1;
		cyc(1);
		fclr = 3'h0;
		fack = 3'h0;
		chk({5'h00, flg}, 8'h04);
		chk({5'h00, irq}, 8'h00);
		// running write equal to compare a: taken, match blocked
		wr_cnt(8'h10);
		chk(cnt, 8'h10);
		cyc(2);
		chk({5'h00, flg}, 8'h04);
		// power off, then oscillator-only ticking
		cs = tmr8_pkg::CLK_STOP;
		wr_cnt(8'hA0);
		pwr = 1'b1;
		cs = tmr8_pkg::CLK_DIV1;
		cyc(5);
		chk(cnt, 8'hA0);
		pwr = 1'b0;
		asel = 1'b1;
		cyc(5);
		chk(cnt, 8'hA0);
		repeat (3)
		begin
			osc = 1'b1;
			cyc(1);
			osc = 1'b0;
			cyc(1);
		end
		chk(cnt, 8'hA3);
		asel = 1'b0;
		// clear on compare a
		cs = tmr8_pkg::CLK_STOP;
		wr_cmp(8'h03);
		wr_cnt(8'h00);
		wm = tmr8_pkg::WM_CTC;
		cs = tmr8_pkg::CLK_DIV1;
		for (int i = 1; i <= 12; i++)
		begin
			cyc(1);
			chk(cnt, 8'(i % 4));
		end
		// force strobes on a stopped counter
		cs = tmr8_pkg::CLK_STOP;
		wm = tmr8_pkg::WM_NORMAL;
		fclr = 3'h7;
		cyc(1);
		fclr = 3'h0;
		for (int k = 0; k < 3; k++)
		begin
			com = '{mode_b: fm[k], mode_a: fm[k]};
			frc = 2'h3;
			cyc(1);
			frc = 2'h0;
			cyc(2);
			chk({6'h00, ob, oa}, (k == 1) ? 8'h00 : 8'h03);
		end
		chk({5'h00, flg}, 8'h00);
		com = '0;
		frc = 2'h3;
		cyc(1);
		frc = 2'h0;
		cyc(2);
		chk({6'h00, ob, oa}, 8'h00);
		com = '{mode_b: tmr8_pkg::COM_TOGGLE, mode_a: tmr8_pkg::COM_TOGGLE};
		cyc(2);
		chk({6'h00, ob, oa}, 8'h03);
		wm = tmr8_pkg::WM_FAST_MAX;
		cyc(2);
		chk({6'h00, ob, oa}, 8'h03);
		// buffered compare view in pwm, active view in normal
		wr_cmp(8'h77);
		chk(cva, 8'h77);
		wm = tmr8_pkg::WM_NORMAL;
		cyc(1);
		chk(cva, 8'h03);
		wr_cmpb(8'h40);
		chk(cvb, 8'h40);
		final_report();
	end
endmodule : tb_top

// *** test/tmr8_core_monitor.sv ***
// tmr8_core_monitor: port assertions for the compare timer core
// assumes binding to tmr8_core, one clock, async active-low reset
`timescale 1ns/1ps
module tmr8_core_monitor
(
	input wire logic			clk,
	input wire logic			rst_b,
	input wire logic			timer_power_off_bit,
	input wire logic			async_clock_select,
	input wire logic [2:0]			clock_select_field,
	input wire logic [2:0]			waveform_mode_field,
	input wire tmr8_pkg::tmr8_com_t		compare_output_mode,
	input wire tmr8_pkg::tmr8_cnt_wr_t	cnt_wr,
	input wire logic			cmp_a_wr,
	input wire logic [1:0]			force_compare_strobe,
	input wire logic [2:0]			interrupt_mask_reg,
	input wire logic [1:0]			port_value,
	input wire logic [7:0]			counter_value,
	input wire logic [7:0]			compare_a_value,
	input wire logic [2:0]			interrupt_flag_reg,
	input wire logic [2:0]			irq,
	input wire logic			compare_a_output
);
	// ticking every cycle with no counter or compare a write in this cycle
	wire	run1 = clock_select_field == tmr8_pkg::CLK_DIV1 && !async_clock_select
		&& !timer_power_off_bit && !cnt_wr.wr && !cmp_a_wr;
	wire	nrm = waveform_mode_field == tmr8_pkg::WM_NORMAL;
	wire	eq_a = counter_value == compare_a_value;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	a_write_wins: assert property (cnt_wr.wr |=> counter_value == $past(cnt_wr.data))
		else $error("counter write not taken");
	a_irq_gate: assert property (irq == (interrupt_flag_reg & $past(interrupt_mask_reg)))
		else $error("request differs from flag and mask");
	a_match_flag: assert property (run1 && $past(run1) && nrm && eq_a |=> interrupt_flag_reg[1])
		else $error("match did not set compare flag");
	a_match_block: assert property ($past(cnt_wr.wr) && nrm && eq_a && !cmp_a_wr
		|=> !$rose(interrupt_flag_reg[1])) else $error("blocked match set flag");
	a_force_set: assert property (force_compare_strobe[0] && nrm
		&& compare_output_mode.mode_a == tmr8_pkg::COM_SET |-> ##[1:2] compare_a_output)
		else $error("forced set did not reach pin");
	a_port_pass: assert property (compare_output_mode.mode_a == tmr8_pkg::COM_NONE
		|=> compare_a_output == $past(port_value[0])) else $error("port value not passed");
	a_ctc_clear: assert property (run1 && $past(run1) && eq_a
		&& waveform_mode_field == tmr8_pkg::WM_CTC |=> counter_value == tmr8_pkg::BOTTOM_VAL)
		else $error("ctc did not clear");
	a_wrap_ovf: assert property (run1 && nrm && counter_value == tmr8_pkg::MAX_VAL
		|=> counter_value == tmr8_pkg::BOTTOM_VAL && interrupt_flag_reg[0])
		else $error("wrap without overflow flag");
endmodule : tmr8_core_monitor

bind tmr8_core tmr8_core_monitor u_mon (.clk, .rst_b, .timer_power_off_bit,
	.async_clock_select, .clock_select_field, .waveform_mode_field, .compare_output_mode,
	.cnt_wr, .cmp_a_wr, .force_compare_strobe, .interrupt_mask_reg, .port_value,
	.counter_value, .compare_a_value, .interrupt_flag_reg, .irq, .compare_a_output);
